/* File: design/srh_monitor_mux.sv */
`timescale 1ns/1ps
module srh_monitor_mux
    import srh_pkg::*;
(
    // Monitor request
    input  wire logic [15:0]                        i_code,
    // Monitor sources from the servo core
    input  wire logic [SRH_MON_COUNT*SRH_MON_W-1:0] i_values,
    // Selected monitor
    output logic      [SRH_MON_W-1:0]               o_data,
    output logic                                    o_valid
);

    // Codes beyond the table answer zero and flag an error response
    always_comb begin
        o_data  = '0;
        o_valid = 1'b0;
        if (i_code < 16'(SRH_MON_COUNT)) begin
            o_data  = i_values[i_code[3:0]*SRH_MON_W +: SRH_MON_W];
            o_valid = 1'b1;
        end
    end

endmodule

/* File: design/srh_remote_request.sv */
`timescale 1ns/1ps
// What this block does
// - Monitor request raises: load monitor data and response, raise monitor acknowledge together.
// - While monitor request stays high, refresh monitor read words every cycle.
// - One station: codes in words 0,1; data in read 0,1; response in read 2.
// - Two stations: monitor 1 result low half read 0, high half read 1.
// - Two stations: monitor 2 code from word 2, result halves in read 5 and 6.
// - Command request rising runs the instruction code held in write word 2.
// - On completion write response into read word 2 and raise command acknowledge.
// - Eight selection bits form a binary point number; zero selects home return.
// - Values 1 to 255 are plain binary weights of the eight selection bits.
// - One station maps only the five low selection bits; upper bits read as zero.
module srh_remote_request
    import srh_pkg::*;
(
    // Clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_rst,
    // Register port
    input  wire logic [SRH_ADDR_W-1:0]               i_addr,
    input  wire logic [SRH_DATA_W-1:0]               i_wr_data,
    input  wire logic                                i_wr_en,
    input  wire logic                                i_rd_en,
    output logic      [SRH_DATA_W-1:0]               o_rd_data,
    // Servo core monitor sources
    input  wire logic [SRH_MON_COUNT*SRH_MON_W-1:0]  i_mon_values,
    // Servo core command execution
    output logic                                     o_cmd_start,
    output logic      [15:0]                         o_cmd_code,
    input  wire logic                                i_cmd_done,
    input  wire logic                                i_cmd_error,
    // Point table selection
    output logic      [SRH_SEL_W-1:0]                o_point_no,
    output logic                                     o_home_select,
    // Acknowledge bits
    output logic                                     o_mon_ack,
    output logic                                     o_cmd_ack,
    // Interrupt
    output logic                                     o_irq
);

    srh_state_t s_q;
    srh_state_t s_d;

    logic [15:0]          mon2_code;
    logic [SRH_MON_W-1:0] mon1_data;
    logic [SRH_MON_W-1:0] mon2_data;
    logic                 mon1_ok;
    logic                 mon2_ok;

    function automatic logic [15:0] resp_code(input logic ok);
        return ok ? SRH_RESP_NORMAL : SRH_RESP_ERROR;
    endfunction

    function automatic logic in_range(input logic [4:0] a, input logic [4:0] lo, input logic [4:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Two stations move monitor 2 code to write word 2
    assign mon2_code = s_q.two_st ? s_q.rww[2] : s_q.rww[1];

    srh_monitor_mux u_mon1 (
        .i_code   (s_q.rww[0]),
        .i_values (i_mon_values),
        .o_data   (mon1_data),
        .o_valid  (mon1_ok)
    );

    srh_monitor_mux u_mon2 (
        .i_code   (mon2_code),
        .i_values (i_mon_values),
        .o_data   (mon2_data),
        .o_valid  (mon2_ok)
    );

    always_comb begin
        logic                 mon_req;
        logic                 cmd_req;
        logic [SRH_IRQ_W-1:0] ev;
        logic [SRH_IRQ_W-1:0] clr;
        logic [SRH_SEL_W-1:0] sel;
        logic [4:0]           idx;
        mon_req = 1'b0;
        cmd_req = 1'b0;
        ev      = '0;
        clr     = '0;
        sel     = '0;
        idx     = '0;
        s_d     = s_q;

        s_d.rdata     = '0;
        s_d.cmd_start = 1'b0;

        // Register writes; read-only offsets and unmapped ones are ignored
        if (i_wr_en) begin
            if (i_addr == SRH_OFS_RY0) begin
                s_d.ry0 = i_wr_data;
            end else if (i_addr == SRH_OFS_RY2) begin
                s_d.ry2 = i_wr_data;
            end else if (in_range(i_addr, SRH_OFS_RWW0, SRH_OFS_RWW3)) begin
                idx = i_addr - SRH_OFS_RWW0;
                s_d.rww[idx[1:0]] = i_wr_data;
            end else if (i_addr == SRH_OFS_CFG) begin
                s_d.two_st = i_wr_data[SRH_CFG_TWO_ST];
            end else if (i_addr == SRH_OFS_IRQ_EN) begin
                s_d.irq_en = i_wr_data[SRH_IRQ_W-1:0];
            end else if (i_addr == SRH_OFS_IRQ_CLR) begin
                clr = i_wr_data[SRH_IRQ_W-1:0];
            end
        end

        // Register reads, data valid only in the following cycle
        if (i_rd_en) begin
            if (i_addr == SRH_OFS_RY0) begin
                s_d.rdata = s_q.ry0;
            end else if (i_addr == SRH_OFS_RY2) begin
                s_d.rdata = s_q.ry2;
            end else if (in_range(i_addr, SRH_OFS_RWW0, SRH_OFS_RWW3)) begin
                idx = i_addr - SRH_OFS_RWW0;
                s_d.rdata = s_q.rww[idx[1:0]];
            end else if (i_addr == SRH_OFS_RX0) begin
                s_d.rdata[SRH_BIT_MON_REQ] = s_q.mon_ack;
                s_d.rdata[SRH_BIT_CMD_REQ] = s_q.cmd_ack;
            end else if (in_range(i_addr, SRH_OFS_RWR0, SRH_OFS_RWR6)) begin
                idx = i_addr - SRH_OFS_RWR0;
                s_d.rdata = s_q.rwr[idx[2:0]];
            end else if (i_addr == SRH_OFS_CFG) begin
                s_d.rdata[SRH_CFG_TWO_ST] = s_q.two_st;
            end else if (i_addr == SRH_OFS_IRQ_STAT) begin
                s_d.rdata[SRH_IRQ_W-1:0] = s_q.irq_st;
            end else if (i_addr == SRH_OFS_IRQ_EN) begin
                s_d.rdata[SRH_IRQ_W-1:0] = s_q.irq_en;
            end
        end

        // Monitor handshake; data follows the live sources each cycle
        mon_req = s_q.ry0[SRH_BIT_MON_REQ];
        if (mon_req) begin
            if (s_q.two_st) begin
                s_d.rwr[0] = mon1_data[15:0];
                s_d.rwr[1] = mon1_data[31:16];
                s_d.rwr[5] = mon2_data[15:0];
                s_d.rwr[6] = mon2_data[31:16];
            end else begin
                s_d.rwr[0] = mon1_data[15:0];
                s_d.rwr[1] = mon2_data[15:0];
            end
            s_d.rwr[2] = resp_code(mon1_ok && mon2_ok);
            s_d.mon_ack = 1'b1;
            if (!s_q.mon_ack) begin
                ev[SRH_IRQ_MON_ACK] = 1'b1;
                ev[SRH_IRQ_MON_ERR] = !(mon1_ok && mon2_ok);
            end
        end else begin
            s_d.mon_ack = 1'b0;
        end

        // Command handshake; only a fresh rising request starts execution
        cmd_req = s_q.ry0[SRH_BIT_CMD_REQ];
        s_d.cmd_req_prev = cmd_req;
        if (cmd_req && !s_q.cmd_req_prev && !s_q.cmd_busy && !s_q.cmd_ack) begin
            s_d.cmd_start = 1'b1;
            s_d.cmd_busy  = 1'b1;
            s_d.cmd_code  = s_q.rww[2];
        end
        if (s_q.cmd_busy && i_cmd_done) begin
            // Completion wins over the monitor refresh of read word 2
            s_d.cmd_busy = 1'b0;
            s_d.rwr[2]   = resp_code(!i_cmd_error);
            s_d.cmd_ack  = cmd_req;
            ev[SRH_IRQ_CMD_DONE] = 1'b1;
            ev[SRH_IRQ_CMD_ERR]  = i_cmd_error;
        end
        if (!cmd_req) begin
            s_d.cmd_ack = 1'b0;
        end

        // Point table selection
        sel[SRH_SEL_LO_W-1:0] = s_q.ry0[SRH_BIT_SEL_LO +: SRH_SEL_LO_W];
        if (s_q.two_st) begin
            sel[SRH_SEL_W-1:SRH_SEL_LO_W] = s_q.ry2[SRH_BIT_SEL_HI +: SRH_SEL_HI_W];
        end
        s_d.point_no = sel;
        s_d.home_sel = (sel == '0);

        // Sticky status: a set in the same cycle beats the clear
        s_d.irq_st = (s_q.irq_st & ~clr) | ev;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= SRH_STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rd_data     = s_q.rdata;
    assign o_cmd_start   = s_q.cmd_start;
    assign o_cmd_code    = s_q.cmd_code;
    assign o_point_no    = s_q.point_no;
    assign o_home_select = s_q.home_sel;
    assign o_mon_ack     = s_q.mon_ack;
    assign o_cmd_ack     = s_q.cmd_ack;
    assign o_irq         = |(s_q.irq_st & s_q.irq_en);

endmodule

/* File: shared/srh_pkg.sv */
package srh_pkg;

    // Register bus
    localparam int unsigned SRH_ADDR_W = 5;
    localparam int unsigned SRH_DATA_W = 16;

    // Register offsets
    localparam logic [4:0] SRH_OFS_RY0       = 5'h00;
    localparam logic [4:0] SRH_OFS_RY2       = 5'h01;
    localparam logic [4:0] SRH_OFS_RWW0      = 5'h02;
    localparam logic [4:0] SRH_OFS_RWW3      = 5'h05;
    localparam logic [4:0] SRH_OFS_RX0       = 5'h08;
    localparam logic [4:0] SRH_OFS_RWR0      = 5'h10;
    localparam logic [4:0] SRH_OFS_RWR6      = 5'h16;
    localparam logic [4:0] SRH_OFS_CFG       = 5'h18;
    localparam logic [4:0] SRH_OFS_IRQ_STAT  = 5'h19;
    localparam logic [4:0] SRH_OFS_IRQ_EN    = 5'h1a;
    localparam logic [4:0] SRH_OFS_IRQ_CLR   = 5'h1b;

    // Remote bit positions
    localparam int unsigned SRH_BIT_MON_REQ  = 8;
    localparam int unsigned SRH_BIT_CMD_REQ  = 9;
    localparam int unsigned SRH_BIT_SEL_LO   = 10;
    localparam int unsigned SRH_SEL_LO_W     = 5;
    localparam int unsigned SRH_BIT_SEL_HI   = 3;
    localparam int unsigned SRH_SEL_HI_W     = 3;
    localparam int unsigned SRH_SEL_W        = 8;

    // Configuration fields
    localparam int unsigned SRH_CFG_TWO_ST   = 0;

    // Interrupt status layout
    localparam int unsigned SRH_IRQ_W        = 4;
    localparam int unsigned SRH_IRQ_MON_ACK  = 0;
    localparam int unsigned SRH_IRQ_MON_ERR  = 1;
    localparam int unsigned SRH_IRQ_CMD_DONE = 2;
    localparam int unsigned SRH_IRQ_CMD_ERR  = 3;

    // Response codes
    localparam logic [15:0] SRH_RESP_NORMAL  = 16'h0000;
    localparam logic [15:0] SRH_RESP_ERROR   = 16'h0001;

    // Monitor source table
    localparam int unsigned SRH_MON_COUNT    = 16;
    localparam int unsigned SRH_MON_W        = 32;
    localparam int unsigned SRH_NUM_RWW      = 4;
    localparam int unsigned SRH_NUM_RWR      = 7;

    typedef struct packed {
        logic [15:0]                      ry0;
        logic [15:0]                      ry2;
        logic [SRH_NUM_RWW-1:0][15:0]     rww;
        logic [SRH_NUM_RWR-1:0][15:0]     rwr;
        logic                             two_st;
        logic [SRH_IRQ_W-1:0]             irq_st;
        logic [SRH_IRQ_W-1:0]             irq_en;
        logic [15:0]                      rdata;
        logic                             mon_ack;
        logic                             cmd_ack;
        logic                             cmd_busy;
        logic                             cmd_req_prev;
        logic                             cmd_start;
        logic [15:0]                      cmd_code;
        logic [SRH_SEL_W-1:0]             point_no;
        logic                             home_sel;
    } srh_state_t;

    localparam srh_state_t SRH_STATE_RESET = '0;

endpackage

/* File: sim/srh_core_model.sv */
`timescale 1ns/1ps
module srh_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_start,
    input  wire logic [3:0] i_lat,
    input  wire logic       i_err,
    output logic            o_done,
    output logic            o_error
);
    int   cnt    = -1;
    logic done_q = 1'b0;
    assign o_done = done_q;
    // Error flag means nothing without done, so show its inverse to catch early sampling
    assign o_error = done_q ? i_err : !i_err;
    always @(posedge i_clk) begin
        done_q <= (cnt == 0);
        cnt <= (i_start === 1'b1) ? int'(i_lat) : (cnt >= 0 ? cnt - 1 : -1);
    end
endmodule

/* File: sim/srh_remote_request_asserts.sv */
`timescale 1ns/1ps
module srh_remote_request_chk
    import srh_pkg::*;
(
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic [SRH_ADDR_W-1:0] i_addr,
    input wire logic [SRH_DATA_W-1:0] i_wr_data,
    input wire logic                  i_wr_en,
    input wire logic                  i_cmd_done,
    input wire logic                  o_cmd_start,
    input wire logic [SRH_SEL_W-1:0]  o_point_no,
    input wire logic                  o_home_select,
    input wire logic                  o_mon_ack,
    input wire logic                  o_cmd_ack,
    input wire logic                  o_irq
);
    logic two_q;
    logic en0_q;
    wire  ry0_wr = i_wr_en && i_addr == SRH_OFS_RY0;
    // Shadows of the station mode and monitor enable, tracked from the write port
    always_ff @(posedge i_clk) begin
        two_q <= i_rst ? 1'b0 : (i_wr_en && i_addr == SRH_OFS_CFG) ? i_wr_data[0] : two_q;
        en0_q <= i_rst ? 1'b0 : (i_wr_en && i_addr == SRH_OFS_IRQ_EN) ? i_wr_data[0] : en0_q;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_mon_on;  ry0_wr && i_wr_data[8];  endsequence
    sequence s_mon_off; ry0_wr && !i_wr_data[8]; endsequence
    sequence s_cmd_off; ry0_wr && !i_wr_data[9]; endsequence
    property p_mon_ack;  s_mon_on |=> ##1 o_mon_ack; endproperty
    property p_mon_drop; s_mon_off |=> ##1 !o_mon_ack; endproperty
    property p_cmd_drop; s_cmd_off |=> ##1 !o_cmd_ack; endproperty
    property p_cmd_start; o_cmd_start |-> $past(ry0_wr && i_wr_data[9], 2) ##1 !o_cmd_start; endproperty
    property p_cmd_ack;  $rose(o_cmd_ack) |-> $past(i_cmd_done); endproperty
    property p_home;     !$past(i_rst) |-> o_home_select == (o_point_no == 8'h00); endproperty
    property p_sel_lo;   ry0_wr |=> ##1 o_point_no[4:0] == $past(i_wr_data[14:10], 2); endproperty
    property p_sel_hi;   !two_q && !$past(two_q) && !$past(i_rst) |-> o_point_no[7:5] == 3'h0; endproperty
    property p_irq;      $rose(o_mon_ack) && en0_q |-> o_irq; endproperty
    a_mon_ack:   assert property (p_mon_ack) else $error("monitor ack late");
    a_mon_drop:  assert property (p_mon_drop) else $error("monitor ack held");
    a_cmd_drop:  assert property (p_cmd_drop) else $error("command ack held");
    a_cmd_start: assert property (p_cmd_start) else $error("bad command start");
    a_cmd_ack:   assert property (p_cmd_ack) else $error("command ack without done");
    a_home:      assert property (p_home) else $error("home select mismatch");
    a_sel_lo:    assert property (p_sel_lo) else $error("low select bits wrong");
    a_sel_hi:    assert property (p_sel_hi) else $error("upper select bits in one station");
    a_irq:       assert property (p_irq) else $error("monitor interrupt missing");
endmodule
bind srh_remote_request srh_remote_request_chk srh_remote_request_chk_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
    .i_cmd_done(i_cmd_done), .o_cmd_start(o_cmd_start), .o_point_no(o_point_no),
    .o_home_select(o_home_select), .o_mon_ack(o_mon_ack), .o_cmd_ack(o_cmd_ack), .o_irq(o_irq)
);

/* File: sim/test_srh_remote_request.sv */
`timescale 1ns/1ps
module test_srh_remote_request
    import srh_pkg::*;
;
    logic         i_clk = 1'b0;
    logic         i_rst = 1'b1;
    logic [4:0]   addr = '0;
    logic [15:0]  wdata = '0;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic [511:0] mv = '0;
    logic [3:0]   lat = '0;
    logic         cerr = 1'b0;
    logic [15:0]  rdata, code;
    logic         start, done, derr, home, mack, cack, irq;
    logic [7:0]   pno;
    logic [15:0]  expq[$];
    int           n_errors = 0;
    int           checks_done = 0;
    int           cyc = 0;
    bit           pend = 0;
    initial forever #25 i_clk = ~i_clk;
    srh_remote_request srh_remote_request_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata), .i_mon_values(mv), .o_cmd_start(start), .o_cmd_code(code),
        .i_cmd_done(done), .i_cmd_error(derr), .o_point_no(pno), .o_home_select(home), .o_mon_ack(mack),
        .o_cmd_ack(cack), .o_irq(irq));
    srh_core_model srh_core_model_inst (.i_clk(i_clk), .i_start(start), .i_lat(lat), .i_err(cerr),
        .o_done(done), .o_error(derr));
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdx(input logic [4:0] a, input logic [15:0] e);
        expq.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic newvals();
        @(posedge i_clk);
        for (int k = 0; k < 16; k++) mv[k*32 +: 32] <= $urandom;
    endtask
    always @(posedge i_clk) begin
        if (pend) chk("read data", rdata, expq.pop_front());
        pend = rd;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        logic [7:0] s;
        logic [7:0] t;
        logic [3:0] c1, c2;
        void'($urandom(32'h13a676a8));
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 16; a < 23; a++) rdx(5'(a), 16'h0000);
        rdx(SRH_OFS_RX0, 16'h0000);
        rdx(5'h1f, 16'h0000);
        $display("reset test done");
        c1 = 4'($urandom);
        c2 = 4'($urandom);
        newvals();
        // Codes go in before the request bit and stay put until acknowledged
        bus(1'b1, SRH_OFS_RWW0, 16'(c1));
        bus(1'b1, SRH_OFS_RWW0 + 5'h01, 16'(c2));
        bus(1'b1, SRH_OFS_IRQ_EN, 16'h0001);
        bus(1'b1, SRH_OFS_RY0, 16'h0100);
        tick(1);
        chk("monitor ack", 16'(mack), 16'h0001);
        chk("irq", 16'(irq), 16'h0001);
        rdx(SRH_OFS_RX0, 16'h0100);
        rdx(SRH_OFS_RWR0, mv[c1*32 +: 16]);
        rdx(SRH_OFS_RWR0 + 5'h01, mv[c2*32 +: 16]);
        rdx(SRH_OFS_RWR0 + 5'h02, SRH_RESP_NORMAL);
        newvals();
        tick(2);
        rdx(SRH_OFS_RWR0, mv[c1*32 +: 16]);
        bus(1'b1, SRH_OFS_CFG, 16'h0001);
        bus(1'b1, SRH_OFS_RWW0 + 5'h02, 16'(c2));
        tick(2);
        rdx(SRH_OFS_RWR0, mv[c1*32 +: 16]);
        rdx(SRH_OFS_RWR0 + 5'h01, mv[c1*32+16 +: 16]);
        rdx(SRH_OFS_RWR0 + 5'h05, mv[c2*32 +: 16]);
        rdx(SRH_OFS_RWR0 + 5'h06, mv[c2*32+16 +: 16]);
        bus(1'b1, SRH_OFS_RWW0, 16'h0010);
        tick(2);
        rdx(SRH_OFS_RWR0, 16'h0000);
        rdx(SRH_OFS_RWR0 + 5'h02, SRH_RESP_ERROR);
        bus(1'b1, SRH_OFS_IRQ_CLR, 16'h000f);
        tick(1);
        chk("irq", 16'(irq), 16'h0000);
        rdx(SRH_OFS_IRQ_STAT, 16'h0000);
        bus(1'b1, SRH_OFS_RY0, 16'h0000);
        tick(1);
        chk("monitor ack", 16'(mack), 16'h0000);
        // Raise again with the bad code still in word 0: both monitor status bits set
        bus(1'b1, SRH_OFS_RY0, 16'h0100);
        tick(1);
        rdx(SRH_OFS_IRQ_STAT, 16'h0003);
        bus(1'b1, SRH_OFS_RY0, 16'h0000);
        tick(1);
        $display("monitor test done");
        for (int e = 0; e < 2; e++) begin
            @(posedge i_clk);
            lat <= 4'($urandom_range(0, 7));
            cerr <= e[0];
            s = 8'($urandom);
            bus(1'b1, SRH_OFS_RWW0 + 5'h02, {8'h00, s});
            bus(1'b1, SRH_OFS_RY0, 16'h0200);
            tick(1);
            chk("command start", 16'(start), 16'h0001);
            chk("command code", code, {8'h00, s});
            for (int k = 0; k < 20 && cack !== 1'b1; k++) tick(1);
            chk("command ack", 16'(cack), 16'h0001);
            rdx(SRH_OFS_RWR0 + 5'h02, e ? SRH_RESP_ERROR : SRH_RESP_NORMAL);
            bus(1'b1, SRH_OFS_RY0, 16'h0000);
            tick(1);
            chk("command ack", 16'(cack), 16'h0000);
        end
        rdx(SRH_OFS_IRQ_STAT, 16'h000f);
        $display("command test done");
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, SRH_OFS_CFG, 16'(m));
            for (int k = 0; k < 6; k++) begin
                s = k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
                t = m ? s : {3'h0, s[4:0]};
                bus(1'b1, SRH_OFS_RY0, {1'b0, s[4:0], 10'h000});
                bus(1'b1, SRH_OFS_RY2, {10'h000, s[7:5], 3'h0});
                tick(1);
                chk("point number", 16'(pno), 16'(t));
                chk("home select", 16'(home), 16'(t == 8'h00));
            end
        end
        $display("point test done");
        final_report();
    end
endmodule
